// file: logic/otsc_regs.sv
// Purpose: Output driver, DAC trim and spur channel configuration bank on AHB-Lite
// Assumes: diff_src, div_pre and div_post are produced by logic on mclk
// Notes: Writes take no wait state; reads insert one wait state
//
// What this block does
// - Doubler field code 01 means doubler off, code 10 means doubler on.
// - Select bit zero routes undivided divider input, one routes divider output.
// - DAC trim is ten bits: low byte at 0x040B, bits 9:8 at 0x040C.
// - Control bit 7 enables channel A cancellation; clear means inactive.
// - Control bit 7 enables channel B cancellation independently of channel A.
// - Bit 6 doubles cancelling gain and the smallest amplitude step.
// - Channel A bits 3:0 pick the target harmonic, one to fifteen.
// - Channel B bits 3:0 pick the target harmonic, one to fifteen.
// - Byte at 0x0501 linearly scales channel A magnitude.
// - Byte at 0x0506 linearly scales channel B magnitude.
// - Channel A phase offset is nine bits over 0x0503 and 0x0504.
// - Channel B phase offset is nine bits over 0x0508 and 0x0509.
// - Control bits 5:4 of both channels are reserved and do nothing.
// - Bit 4 inverts differential output polarity; bits 3:2 are reserved.
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module otsc_regs (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic diff_src,
  input wire logic div_pre,
  input wire logic div_post,
  output logic diff_drive,
  output logic se_drive,
  output otsc_pkg::otsc_cfg_s cfg
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Cancellation amplitude: magnitude times one or two, zero when off
  function automatic logic [8:0] spur_amp(input logic on, input logic gain_x2,
                                          input logic [7:0] magnitude);
    logic [8:0] amp;
    amp = {1'b0, magnitude};
    if (gain_x2) begin
      amp = {magnitude, 1'b0};
    end
    if (!on) begin
      amp = 9'h000;
    end
    return amp;
  endfunction : spur_amp

  // Maps a word index to {hit, slot}
  function automatic logic [otsc_pkg::SLOT_W:0] decode(input logic [otsc_pkg::IDX_W-1:0] idx);
    logic [otsc_pkg::SLOT_W:0] res;
    res = '0;
    for (int i = 0; i < otsc_pkg::NREG; i++) begin
      if (idx == otsc_pkg::REG_IDX[i]) begin
        res = {1'b1, i[otsc_pkg::SLOT_W-1:0]};
      end
    end
    if (idx == otsc_pkg::IDX_STATUS) begin
      res = {1'b1, 4'(otsc_pkg::SL_STAT)};
    end
    return res;
  endfunction : decode

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  otsc_pkg::otsc_bus_e state;
  otsc_pkg::otsc_bus_e next_state;
  logic addr_phase;
  logic hit;
  logic [otsc_pkg::SLOT_W-1:0] slot;
  logic [otsc_pkg::SLOT_W:0] dec;
  logic [7:0] q [otsc_pkg::NREG];
  logic [7:0] status;
  logic [7:0] rd_byte;
  logic [otsc_pkg::NREG-1:0] wr_en;

  assign addr_phase = hsel && hready && htrans[1];
  assign dec = decode(haddr[otsc_pkg::IDX_W+1:2]);
  assign hreadyout = (state != otsc_pkg::BUS_RD_WAIT);
  assign hresp = 1'b0;

  always_comb begin
    next_state = otsc_pkg::BUS_IDLE;
    unique case (state)
      otsc_pkg::BUS_RD_WAIT: begin
        next_state = otsc_pkg::BUS_RD_DONE;
      end
      otsc_pkg::BUS_IDLE, otsc_pkg::BUS_WR, otsc_pkg::BUS_RD_DONE: begin
        if (addr_phase) begin
          next_state = hwrite ? otsc_pkg::BUS_WR : otsc_pkg::BUS_RD_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= otsc_pkg::BUS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Address phase is captured only when a new transfer is accepted
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hit <= 1'b0;
      slot <= '0;
    end else if (hreadyout && addr_phase) begin
      hit <= dec[otsc_pkg::SLOT_W];
      slot <= dec[otsc_pkg::SLOT_W-1:0];
    end
  end

  // Status is read only; a write to it or to an unmapped word is dropped
  always_comb begin
    for (int i = 0; i < otsc_pkg::NREG; i++) begin
      wr_en[i] = (state == otsc_pkg::BUS_WR) && hit && (slot == i[otsc_pkg::SLOT_W-1:0]);
    end
  end

  generate
    for (genvar g = 0; g < otsc_pkg::NREG; g++) begin : g_reg
      otsc_cfg_byte #(
        .WMASK(otsc_pkg::REG_WMASK[g]),
        .RESET(otsc_pkg::REG_RESET[g])
      ) u_byte (
        .mclk(mclk),
        .rst(rst),
        .wr_en(wr_en[g]),
        .wdata(hwdata[7:0]),
        .q(q[g])
      );
    end
  endgenerate

  always_comb begin
    rd_byte = 8'h00;
    if (hit && (slot == 4'(otsc_pkg::SL_STAT))) begin
      rd_byte = status;
    end else if (hit) begin
      rd_byte = q[slot];
    end
  end

  // Read data is taken in the wait cycle, after any preceding write landed
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (state == otsc_pkg::BUS_RD_WAIT) begin
      hrdata <= {24'h00_0000, rd_byte};
    end
  end

  // ****************************************************************
  // Configuration decode
  // ****************************************************************
  otsc_pkg::otsc_cfg_s next_cfg;
  logic [1:0] dbl_code;

  assign dbl_code = q[otsc_pkg::SL_DIFF][1:0];

  always_comb begin
    // Codes 00 and 11 are undefined and leave the doubler off
    next_cfg.doubler_on = (dbl_code == otsc_pkg::DBL_ON);
    next_cfg.diff_output_invert = q[otsc_pkg::SL_DIFF][otsc_pkg::DIFF_INV_BIT];
    next_cfg.se_src_divided = q[otsc_pkg::SL_SE][otsc_pkg::SE_SRC_BIT];
    next_cfg.dac_trim = {q[otsc_pkg::SL_TRIM_HI][1:0], q[otsc_pkg::SL_TRIM_LO]};
    next_cfg.chan_a.on = q[otsc_pkg::SL_A_CTL][otsc_pkg::SPUR_ON_BIT];
    next_cfg.chan_a.gain_x2 = q[otsc_pkg::SL_A_CTL][otsc_pkg::SPUR_GAIN_BIT];
    next_cfg.chan_a.harmonic = q[otsc_pkg::SL_A_CTL][otsc_pkg::SPUR_HARM_MSB:0];
    next_cfg.chan_a.magnitude = q[otsc_pkg::SL_A_MAG];
    next_cfg.chan_a.phase = {q[otsc_pkg::SL_A_PH_HI][0], q[otsc_pkg::SL_A_PH_LO]};
    next_cfg.chan_a.amplitude = spur_amp(next_cfg.chan_a.on, next_cfg.chan_a.gain_x2,
                                         next_cfg.chan_a.magnitude);
    next_cfg.chan_b.on = q[otsc_pkg::SL_B_CTL][otsc_pkg::SPUR_ON_BIT];
    next_cfg.chan_b.gain_x2 = q[otsc_pkg::SL_B_CTL][otsc_pkg::SPUR_GAIN_BIT];
    next_cfg.chan_b.harmonic = q[otsc_pkg::SL_B_CTL][otsc_pkg::SPUR_HARM_MSB:0];
    next_cfg.chan_b.magnitude = q[otsc_pkg::SL_B_MAG];
    next_cfg.chan_b.phase = {q[otsc_pkg::SL_B_PH_HI][0], q[otsc_pkg::SL_B_PH_LO]};
    next_cfg.chan_b.amplitude = spur_amp(next_cfg.chan_b.on, next_cfg.chan_b.gain_x2,
                                         next_cfg.chan_b.magnitude);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg <= '0;
    end else begin
      cfg <= next_cfg;
    end
  end

  // Status: effective doubler, undefined doubler code, channels cancelling
  always_comb begin
    status = 8'h00;
    status[otsc_pkg::ST_DBL_ON_BIT] = cfg.doubler_on;
    status[otsc_pkg::ST_DBL_BAD_BIT] = (dbl_code != otsc_pkg::DBL_ON)
                                       && (dbl_code != otsc_pkg::DBL_OFF);
    status[otsc_pkg::ST_A_ACT_BIT] = cfg.chan_a.on && (cfg.chan_a.harmonic != 4'h0);
    status[otsc_pkg::ST_B_ACT_BIT] = cfg.chan_b.on && (cfg.chan_b.harmonic != 4'h0);
  end

  // ****************************************************************
  // Output drivers
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      diff_drive <= 1'b0;
    end else begin
      diff_drive <= diff_src ^ cfg.diff_output_invert;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      se_drive <= 1'b0;
    end else begin
      se_drive <= cfg.se_src_divided ? div_post : div_pre;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_write_addr(logic [otsc_pkg::IDX_W-1:0] idx);
    addr_phase && hreadyout && hwrite && (haddr[otsc_pkg::IDX_W+1:2] == idx);
  endsequence

  sequence s_read_addr;
    addr_phase && hreadyout && !hwrite;
  endsequence

  a_doubler_code: assert property (@(posedge mclk) disable iff (rst)
    (dbl_code == otsc_pkg::DBL_ON) |=> cfg.doubler_on)
    else $error("doubler code 10 did not turn doubler on");

  a_doubler_off: assert property (@(posedge mclk) disable iff (rst)
    (dbl_code == otsc_pkg::DBL_OFF) |=> !cfg.doubler_on)
    else $error("doubler code 01 did not turn doubler off");

  a_se_source: assert property (@(posedge mclk) disable iff (rst)
    ##1 se_drive == $past(cfg.se_src_divided ? div_post : div_pre))
    else $error("single-ended driver source wrong");

  a_se_select: assert property (@(posedge mclk) disable iff (rst)
    ##1 cfg.se_src_divided == $past(q[otsc_pkg::SL_SE][otsc_pkg::SE_SRC_BIT]))
    else $error("single-ended source select not taken from register");

  a_trim_write: assert property (@(posedge mclk) disable iff (rst)
    s_write_addr(otsc_pkg::IDX_DAC_CURRENT_TRIM_HIGH) ##1 1'b1
    |=> ##1 cfg.dac_trim[9:8] == $past(hwdata[1:0], 2))
    else $error("trim high bits not taken from write");

  a_trim_low: assert property (@(posedge mclk) disable iff (rst)
    s_write_addr(otsc_pkg::IDX_DAC_CURRENT_TRIM_LOW) ##1 1'b1
    |=> ##1 cfg.dac_trim[7:0] == $past(hwdata[7:0], 2))
    else $error("trim low bits not taken from write");

  a_chan_a_on: assert property (@(posedge mclk) disable iff (rst)
    !q[otsc_pkg::SL_A_CTL][7] |=> (cfg.chan_a.amplitude == 9'h000) && !cfg.chan_a.on)
    else $error("channel A active while disabled");

  a_chan_b_on: assert property (@(posedge mclk) disable iff (rst)
    ##1 cfg.chan_b.on == $past(q[otsc_pkg::SL_B_CTL][7]))
    else $error("channel B enable wrong");

  a_chan_b_off: assert property (@(posedge mclk) disable iff (rst)
    !q[otsc_pkg::SL_B_CTL][7] |=> (cfg.chan_b.amplitude == 9'h000) && !cfg.chan_b.on)
    else $error("channel B active while disabled");

  a_gain_double: assert property (@(posedge mclk) disable iff (rst)
    cfg.chan_a.on && cfg.chan_a.gain_x2
    |-> cfg.chan_a.amplitude == {cfg.chan_a.magnitude, 1'b0})
    else $error("channel A gain not doubled");

  a_gain_b_double: assert property (@(posedge mclk) disable iff (rst)
    cfg.chan_b.on && cfg.chan_b.gain_x2
    |-> cfg.chan_b.amplitude == {cfg.chan_b.magnitude, 1'b0})
    else $error("channel B gain not doubled");

  a_gain_single: assert property (@(posedge mclk) disable iff (rst)
    cfg.chan_b.on && !cfg.chan_b.gain_x2
    |-> cfg.chan_b.amplitude == {1'b0, cfg.chan_b.magnitude})
    else $error("channel B amplitude not unity");

  a_gain_a_single: assert property (@(posedge mclk) disable iff (rst)
    cfg.chan_a.on && !cfg.chan_a.gain_x2
    |-> cfg.chan_a.amplitude == {1'b0, cfg.chan_a.magnitude})
    else $error("channel A amplitude not unity");

  a_magnitude_pass: assert property (@(posedge mclk) disable iff (rst)
    ##1 (cfg.chan_a.magnitude == $past(q[otsc_pkg::SL_A_MAG]))
    && (cfg.chan_b.magnitude == $past(q[otsc_pkg::SL_B_MAG])))
    else $error("magnitude multiplier not taken from register");

  a_harm_sel: assert property (@(posedge mclk) disable iff (rst)
    ##1 (cfg.chan_a.harmonic == $past(q[otsc_pkg::SL_A_CTL][3:0]))
    && (cfg.chan_b.harmonic == $past(q[otsc_pkg::SL_B_CTL][3:0])))
    else $error("harmonic select wrong");

  a_phase_join: assert property (@(posedge mclk) disable iff (rst)
    ##1 (cfg.chan_a.phase[8] == $past(q[otsc_pkg::SL_A_PH_HI][0]))
    && (cfg.chan_b.phase == $past({q[otsc_pkg::SL_B_PH_HI][0], q[otsc_pkg::SL_B_PH_LO]})))
    else $error("phase offset assembly wrong");

  a_phase_low_a: assert property (@(posedge mclk) disable iff (rst)
    ##1 cfg.chan_a.phase[7:0] == $past(q[otsc_pkg::SL_A_PH_LO]))
    else $error("channel A phase low byte wrong");

  a_reserved_zero: assert property (@(posedge mclk) disable iff (rst)
    (q[otsc_pkg::SL_A_CTL][5:4] == 2'b00) && (q[otsc_pkg::SL_B_CTL][5:4] == 2'b00)
    && (q[otsc_pkg::SL_DIFF][3:2] == 2'b00))
    else $error("reserved bits hold a value");

  a_invert_out: assert property (@(posedge mclk) disable iff (rst)
    ##1 diff_drive == ($past(diff_src) ^ $past(cfg.diff_output_invert)))
    else $error("differential polarity wrong");

  a_rdata_upper: assert property (@(posedge mclk) disable iff (rst)
    hrdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");

  a_resp_okay: assert property (@(posedge mclk) disable iff (rst)
    hresp == 1'b0)
    else $error("bus response not okay");

  a_read_wait: assert property (@(posedge mclk) disable iff (rst)
    s_read_addr |=> !hreadyout ##1 hreadyout)
    else $error("read did not take exactly one wait state");

endmodule : otsc_regs

`default_nettype wire

// file: logic/otsc_pkg.sv
// Purpose: Shared constants and types for the output trim and spur configuration bank
// Assumes: Registers are bytes in the low lane of aligned 32-bit AHB-Lite words
// Notes: Byte address of a register is four times its index
`default_nettype none

package otsc_pkg;

  // ****************************************************************
  // Register indices and layout
  // ****************************************************************
  localparam int NREG = 12;
  localparam int IDX_W = 12;
  localparam int SLOT_W = 4;

  localparam int SL_DIFF = 0;
  localparam int SL_SE = 1;
  localparam int SL_TRIM_LO = 2;
  localparam int SL_TRIM_HI = 3;
  localparam int SL_A_CTL = 4;
  localparam int SL_A_MAG = 5;
  localparam int SL_A_PH_LO = 6;
  localparam int SL_A_PH_HI = 7;
  localparam int SL_B_CTL = 8;
  localparam int SL_B_MAG = 9;
  localparam int SL_B_PH_LO = 10;
  localparam int SL_B_PH_HI = 11;
  localparam int SL_STAT = 12;

  localparam logic [IDX_W-1:0] IDX_DIFF_DRIVER = 12'h0200;
  localparam logic [IDX_W-1:0] IDX_SINGLE_ENDED_DRIVER_SOURCE = 12'h0201;
  localparam logic [IDX_W-1:0] IDX_DAC_CURRENT_TRIM_LOW = 12'h040B;
  localparam logic [IDX_W-1:0] IDX_DAC_CURRENT_TRIM_HIGH = 12'h040C;
  localparam logic [IDX_W-1:0] IDX_SPUR_CHAN_A_CONTROL = 12'h0500;
  localparam logic [IDX_W-1:0] IDX_SPUR_CHAN_A_MAGNITUDE = 12'h0501;
  localparam logic [IDX_W-1:0] IDX_SPUR_CHAN_A_PHASE_LOW = 12'h0503;
  localparam logic [IDX_W-1:0] IDX_SPUR_CHAN_A_PHASE_HIGH = 12'h0504;
  localparam logic [IDX_W-1:0] IDX_SPUR_CHAN_B_CONTROL = 12'h0505;
  localparam logic [IDX_W-1:0] IDX_SPUR_CHAN_B_MAGNITUDE = 12'h0506;
  localparam logic [IDX_W-1:0] IDX_SPUR_CHAN_B_PHASE_LOW = 12'h0508;
  localparam logic [IDX_W-1:0] IDX_SPUR_CHAN_B_PHASE_HIGH = 12'h0509;
  localparam logic [IDX_W-1:0] IDX_STATUS = 12'h0511;

  localparam logic [IDX_W-1:0] REG_IDX [NREG] = '{
    IDX_DIFF_DRIVER, IDX_SINGLE_ENDED_DRIVER_SOURCE,
    IDX_DAC_CURRENT_TRIM_LOW, IDX_DAC_CURRENT_TRIM_HIGH,
    IDX_SPUR_CHAN_A_CONTROL, IDX_SPUR_CHAN_A_MAGNITUDE,
    IDX_SPUR_CHAN_A_PHASE_LOW, IDX_SPUR_CHAN_A_PHASE_HIGH,
    IDX_SPUR_CHAN_B_CONTROL, IDX_SPUR_CHAN_B_MAGNITUDE,
    IDX_SPUR_CHAN_B_PHASE_LOW, IDX_SPUR_CHAN_B_PHASE_HIGH};

  // Writable bits; everything else is reserved and reads zero
  localparam logic [7:0] REG_WMASK [NREG] = '{
    8'h13, 8'h01, 8'hFF, 8'h03, 8'hCF, 8'hFF,
    8'hFF, 8'h01, 8'hCF, 8'hFF, 8'hFF, 8'h01};

  // Doubler field comes up in its off code
  localparam logic [7:0] REG_RESET [NREG] = '{
    8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // ****************************************************************
  // Field positions and codes
  // ****************************************************************
  localparam int DIFF_INV_BIT = 4;
  localparam int SE_SRC_BIT = 0;
  localparam int SPUR_ON_BIT = 7;
  localparam int SPUR_GAIN_BIT = 6;
  localparam int SPUR_HARM_MSB = 3;
  localparam int ST_DBL_ON_BIT = 0;
  localparam int ST_DBL_BAD_BIT = 1;
  localparam int ST_A_ACT_BIT = 2;
  localparam int ST_B_ACT_BIT = 3;
  localparam logic [1:0] DBL_OFF = 2'h1;
  localparam logic [1:0] DBL_ON = 2'h2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WR = 2'b01,
    BUS_RD_WAIT = 2'b10,
    BUS_RD_DONE = 2'b11
  } otsc_bus_e;

  typedef struct packed {
    logic on;
    logic gain_x2;
    logic [3:0] harmonic;
    logic [7:0] magnitude;
    logic [8:0] phase;
    logic [8:0] amplitude;
  } otsc_spur_s;

  typedef struct packed {
    logic doubler_on;
    logic diff_output_invert;
    logic se_src_divided;
    logic [9:0] dac_trim;
    otsc_spur_s chan_a;
    otsc_spur_s chan_b;
  } otsc_cfg_s;

endpackage : otsc_pkg

`default_nettype wire

// file: logic/otsc_cfg_byte.sv
// Purpose: One byte-wide configuration register with a writable-bit mask
// Assumes: Write enable and data come from logic on mclk
// Notes: Bits outside the mask hold zero and ignore writes
`timescale 1ns/100ps
`default_nettype none

module otsc_cfg_byte #(
  parameter logic [7:0] WMASK = 8'hFF,
  parameter logic [7:0] RESET = 8'h00
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  output logic [7:0] q
);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= RESET & WMASK;
    end else if (wr_en) begin
      q <= wdata & WMASK;
    end
  end

endmodule : otsc_cfg_byte

`default_nettype wire

// file: bench/otsc_regs_bench.sv
// Purpose: Self-checking bench for the output trim and spur configuration bank
// Assumes: AHB-Lite single word transfers; hready is looped back from hreadyout
// Notes: Each scenario is one task; cfg and drivers are checked two edges after a write
`timescale 1ns/100ps
`default_nettype none

module otsc_regs_bench;
  logic mclk, rst, hsel, hwrite, diff_src, div_pre, div_post;
  logic [31:0] haddr, hwdata, hrdata, last_rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, diff_drive, se_drive;
  otsc_pkg::otsc_cfg_s cfg;
  int mismatches, checked;
  // Word index outside this bank; a write to it is dropped and changes nothing
  localparam logic [11:0] IDX_CORE_CFG = 12'h010;

  otsc_regs i_otsc_regs (
    .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .diff_src(diff_src), .div_pre(div_pre),
    .div_post(div_post), .diff_drive(diff_drive), .se_drive(se_drive), .cfg(cfg)
  );

  // ****************************************************************
  // Clock, checking and bus tasks
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Sample hready mid-cycle, where it is settled, and act at the following edge
  task automatic wait_ready();
    logic ok;
    ok = 1'b0;
    while (!ok) begin
      @(negedge mclk);
      ok = (hreadyout === 1'b1);
      last_rd = hrdata;
      @(posedge mclk);
    end
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {18'h0_0000, idx, 2'h0};
    hwrite <= wr;
    htrans <= otsc_pkg::HTRANS_NONSEQ;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, wd};
    wait_ready();
    check("hresp", {31'h0, hresp}, 32'h0000_0000);
  endtask : bus

  task automatic settle();
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask : settle

  task automatic rd_check(input string what, input logic [11:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check(what, last_rd, {24'h00_0000, exp});
  endtask : rd_check

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic reset_values();
    for (int i = 0; i < otsc_pkg::NREG; i++) begin
      rd_check("reset value", otsc_pkg::REG_IDX[i], otsc_pkg::REG_RESET[i]);
    end
  endtask : reset_values

  task automatic diff_driver();
    logic [1:0] code;
    for (int c = 0; c < 4; c++) begin
      code = c[1:0];
      bus(1'b1, otsc_pkg::IDX_DIFF_DRIVER, {3'h7, c[0], 2'h3, code});
      if (code == otsc_pkg::DBL_ON) begin
        bus(1'b1, IDX_CORE_CFG, 8'h20);
      end
      @(posedge mclk);
      diff_src <= c[1];
      settle();
      check("doubler_on", {31'h0, cfg.doubler_on}, {31'h0, code == otsc_pkg::DBL_ON});
      check("invert", {31'h0, cfg.diff_output_invert}, {31'h0, c[0]});
      check("diff_drive", {31'h0, diff_drive}, {31'h0, c[1] ^ c[0]});
      rd_check("diff reg", otsc_pkg::IDX_DIFF_DRIVER, {3'h0, c[0], 2'h0, code});
      rd_check("status dbl", otsc_pkg::IDX_STATUS,
               {6'h00, code == 2'h0 || code == 2'h3, code == otsc_pkg::DBL_ON});
    end
    // Back to the off code so later status reads see a legal doubler code
    bus(1'b1, otsc_pkg::IDX_DIFF_DRIVER, {6'h00, otsc_pkg::DBL_OFF});
    settle();
    check("doubler off", {31'h0, cfg.doubler_on}, 32'h0000_0000);
  endtask : diff_driver

  task automatic se_source();
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, otsc_pkg::IDX_SINGLE_ENDED_DRIVER_SOURCE, {7'h7F, c[0]});
      @(posedge mclk);
      div_pre <= c[1];
      div_post <= ~c[1];
      settle();
      check("se_src", {31'h0, cfg.se_src_divided}, {31'h0, c[0]});
      check("se_drive", {31'h0, se_drive}, {31'h0, c[0] ? ~c[1] : c[1]});
    end
    rd_check("se reg", otsc_pkg::IDX_SINGLE_ENDED_DRIVER_SOURCE, 8'h01);
  endtask : se_source

  task automatic dac_trim();
    bus(1'b1, otsc_pkg::IDX_DAC_CURRENT_TRIM_LOW, 8'hA5);
    bus(1'b1, otsc_pkg::IDX_DAC_CURRENT_TRIM_HIGH, 8'hFE);
    settle();
    check("dac_trim", {22'h0, cfg.dac_trim}, 32'h0000_02A5);
    rd_check("trim hi", otsc_pkg::IDX_DAC_CURRENT_TRIM_HIGH, 8'h02);
    rd_check("trim lo", otsc_pkg::IDX_DAC_CURRENT_TRIM_LOW, 8'hA5);
  endtask : dac_trim

  task automatic spur_chan(input logic ch);
    logic [11:0] b;
    logic [7:0] ctl;
    logic [8:0] amp;
    otsc_pkg::otsc_spur_s sp, other;
    b = ch ? otsc_pkg::IDX_SPUR_CHAN_B_CONTROL : otsc_pkg::IDX_SPUR_CHAN_A_CONTROL;
    bus(1'b1, b + 12'h001, 8'h9C);
    bus(1'b1, b + 12'h003, 8'h5A);
    bus(1'b1, b + 12'h004, 8'hFF);
    for (int h = 1; h < 16; h++) begin
      ctl = {h[0], h[1], 2'h3, h[3:0]};
      bus(1'b1, b, ctl);
      settle();
      sp = ch ? cfg.chan_b : cfg.chan_a;
      other = ch ? cfg.chan_a : cfg.chan_b;
      amp = !h[0] ? 9'h000 : (h[1] ? 9'h138 : 9'h09C);
      check("spur on", {31'h0, sp.on}, {31'h0, h[0]});
      check("other on", {31'h0, other.on}, 32'h0000_0000);
      check("gain", {31'h0, sp.gain_x2}, {31'h0, h[1]});
      check("amplitude", {23'h0, sp.amplitude}, {23'h0, amp});
      check("harmonic", {28'h0, sp.harmonic}, {28'h0, h[3:0]});
      rd_check("spur ctl", b, ctl & 8'hCF);
    end
    check("magnitude", {24'h0, sp.magnitude}, 32'h0000_009C);
    check("phase", {23'h0, sp.phase}, 32'h0000_015A);
    rd_check("phase hi", b + 12'h004, 8'h01);
    rd_check("status act", otsc_pkg::IDX_STATUS, {4'h0, ch, ~ch, 2'h0});
    bus(1'b1, b, 8'h00);
  endtask : spur_chan

  task automatic unmapped();
    bus(1'b1, 12'h000, 8'hFF);
    rd_check("unmapped", 12'h000, 8'h00);
    bus(1'b1, otsc_pkg::IDX_STATUS, 8'hFF);
    rd_check("status ro", otsc_pkg::IDX_STATUS, 8'h00);
  endtask : unmapped

  // ****************************************************************
  // Sequence, watchdog and verdict
  // ****************************************************************
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    diff_src = 1'b0;
    div_pre = 1'b0;
    div_post = 1'b0;
    mismatches = 0;
    checked = 0;
    repeat (19) @(posedge mclk);
    @(negedge mclk);
    check("cfg in reset", {31'h0, cfg === '0}, 32'h0000_0001);
    check("hreadyout in reset", {31'h0, hreadyout}, 32'h0000_0001);
    @(posedge mclk);
    rst <= 1'b0;
    reset_values();
    diff_driver();
    se_source();
    dac_trim();
    spur_chan(1'b0);
    spur_chan(1'b1);
    unmapped();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    $display("wrong value watchdog expected done seen hang");
    stop_test();
  end
endmodule : otsc_regs_bench

`default_nettype wire
